/* verilog/hts_target.sv */
// serial target front end with reset and conversion timing
`include "hts_consts.svh"
module hts_target #(
	parameter int RST_SEQ_CYC = `HTS_RST_SEQ_CYC,
	parameter int SOFT_RST_CYC = `HTS_SOFT_RST_CYC,
	parameter int US_CYC = `HTS_CLK_MHZ
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// pins
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic addrSelectStrap,
	input wire logic rstPin_n,
	// factory configuration of the alternate address
	input wire logic altAddrEnable,
	input wire logic [6:0] altAddr,
	// sensor data side
	input wire logic [15:0] tempData,
	input wire logic [15:0] humData,
	output logic measBusy,
	output logic measDone,
	output logic sensorReady,
	output logic [1:0] humLevel,
	output logic [1:0] tempLevel
);
	import hts_pkg::*;

	function automatic logic [31:0] humUs(input logic [1:0] l);
		case (l)
			2'h3: humUs = `HTS_HUM3_US;
			2'h2: humUs = `HTS_HUM2_US;
			2'h1: humUs = `HTS_HUM1_US;
			default: humUs = `HTS_HUM0_US;
		endcase
	endfunction : humUs

	function automatic logic [31:0] tmpUs(input logic [1:0] l);
		case (l)
			2'h3: tmpUs = `HTS_TMP3_US;
			2'h2: tmpUs = `HTS_TMP2_US;
			2'h1: tmpUs = `HTS_TMP1_US;
			default: tmpUs = `HTS_TMP0_US;
		endcase
	endfunction : tmpUs

	typedef struct packed {
		logic [1:0] sclSync;
		logic [1:0] sdaSync;
		logic [1:0] strapSync;
		logic [1:0] rstSync;
		logic sclPrev;
		logic sdaPrev;
		hts_bus_e bus;
		logic [3:0] bitCnt;
		logic [7:0] shift;
		logic rnw;
		logic [2:0] byteIdx;
		logic sdaOut;
		logic sdaOe;
		logic [15:0] rstCnt;
		logic inReset;
		hts_meas_e meas;
		logic measDone;
		logic [1:0] humLevel;
		logic [1:0] tempLevel;
		logic timerLoad;
		logic [31:0] timerCount;
		logic readHumOnly;
		logic busy;
		logic ready;
	} hts_state_s;
	hts_state_s st, next_st;

	logic timerBusy;
	logic timerDone;

	hts_timer #(.W(32)) u_timer (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.load(st.timerLoad),
		.count(st.timerCount),
		.busy(timerBusy),
		.done(timerDone)
	);

	logic sclRise, sclFall, startCond, stopCond;
	logic [6:0] ownAddr;
	logic [7:0] rxByte;
	logic [7:0] txByte;

	assign sclRise = st.sclSync[1] && !st.sclPrev;
	assign sclFall = !st.sclSync[1] && st.sclPrev;
	// start/stop only count while the clock is high
	assign startCond = st.sclSync[1] && st.sclPrev && st.sdaPrev && !st.sdaSync[1];
	assign stopCond = st.sclSync[1] && st.sclPrev && !st.sdaPrev && st.sdaSync[1];
	assign ownAddr = {`HTS_ADDR_BASE, st.strapSync[1]};
	assign rxByte = {st.shift[6:0], st.sdaSync[1]};

	// crc bytes are not modelled here; they read as zero
	always_comb begin
		txByte = 8'h00;
		case (st.byteIdx)
			3'h0: txByte = st.readHumOnly ? humData[15:8] : tempData[15:8];
			3'h1: txByte = st.readHumOnly ? humData[7:0] : tempData[7:0];
			3'h3: txByte = st.readHumOnly ? 8'h00 : humData[15:8];
			3'h4: txByte = st.readHumOnly ? 8'h00 : humData[7:0];
			default: txByte = 8'h00;
		endcase
	end

	always_comb begin
		next_st = st;
		next_st.sclSync = {st.sclSync[0], sclIn};
		next_st.sdaSync = {st.sdaSync[0], sdaIn};
		next_st.strapSync = {st.strapSync[0], addrSelectStrap};
		next_st.rstSync = {st.rstSync[0], rstPin_n};
		next_st.sclPrev = st.sclSync[1];
		next_st.sdaPrev = st.sdaSync[1];
		next_st.timerLoad = 1'b0;
		next_st.measDone = 1'b0;

		// pin reset: count active cycles, fire once at the minimum width
		if (!st.rstSync[1]) begin
			if (st.rstCnt < 16'(`HTS_RST_PULSE_CYC)) begin
				next_st.rstCnt = st.rstCnt + 16'h0001;
			end
		end else begin
			next_st.rstCnt = 16'h0000;
		end
		if (!st.rstSync[1] && st.rstCnt == 16'(`HTS_RST_PULSE_CYC - 1)) begin
			next_st.inReset = 1'b1;
			next_st.meas = MS_RESET;
			next_st.timerLoad = 1'b1;
			next_st.timerCount = 32'(RST_SEQ_CYC);
			next_st.humLevel = 2'h0;
			next_st.tempLevel = 2'h0;
		end

		// event-driven only: no timeout on a stalled clock, state just waits
		if (st.inReset) begin
			next_st.bus = ST_IDLE;
			next_st.sdaOe = 1'b0;
		end else if (startCond) begin
			next_st.bus = ST_ADDR;
			next_st.bitCnt = 4'h0;
			next_st.sdaOe = 1'b0;
		end else if (stopCond) begin
			next_st.bus = ST_IDLE;
			next_st.sdaOe = 1'b0;
		end else begin
			case (st.bus)
				ST_ADDR, ST_WRITE: begin
					if (sclRise) begin
						next_st.shift = rxByte;
						next_st.bitCnt = st.bitCnt + 4'h1;
					end
					if (sclFall && st.bitCnt == 4'h8) begin
						if (st.bus == ST_ADDR) begin
							// alternate address stays off unless factory-enabled
							if (st.shift[7:1] == ownAddr ||
									(altAddrEnable && st.shift[7:1] == altAddr)) begin
								next_st.rnw = st.shift[0];
								next_st.byteIdx = 3'h0;
								next_st.sdaOut = 1'b0;
								next_st.sdaOe = 1'b1;
								next_st.bus = ST_ACK;
							end else begin
								next_st.bus = ST_SKIP;
							end
						end else begin
							next_st.sdaOut = 1'b0;
							next_st.sdaOe = 1'b1;
							next_st.bus = ST_ACK;
							if ((st.shift & `HTS_CMD_CONV_MASK) == `HTS_CMD_CONV &&
									st.meas == MS_IDLE) begin
								next_st.humLevel = st.shift[`HTS_HUM_LSB +: 2];
								next_st.tempLevel = st.shift[`HTS_TMP_LSB +: 2];
								next_st.meas = MS_CONV;
								next_st.timerLoad = 1'b1;
								// both run together; the slower one sets the finish
								next_st.timerCount = 32'(US_CYC) *
									((humUs(st.shift[`HTS_HUM_LSB +: 2]) >
									tmpUs(st.shift[`HTS_TMP_LSB +: 2])) ?
									humUs(st.shift[`HTS_HUM_LSB +: 2]) :
									tmpUs(st.shift[`HTS_TMP_LSB +: 2]));
							end else if ((st.shift & `HTS_CMD_RESET_MASK) == `HTS_CMD_RESET) begin
								next_st.meas = MS_RESET;
								next_st.timerLoad = 1'b1;
								next_st.timerCount = 32'(SOFT_RST_CYC);
								next_st.humLevel = 2'h0;
								next_st.tempLevel = 2'h0;
							end else if ((st.shift & `HTS_CMD_RESET_MASK) == `HTS_CMD_READ_RH) begin
								next_st.readHumOnly = 1'b1;
							end else if ((st.shift & `HTS_CMD_RESET_MASK) == `HTS_CMD_READ_TRH) begin
								next_st.readHumOnly = 1'b0;
							end
						end
					end
				end
				ST_ACK: begin
					if (sclFall) begin
						next_st.bitCnt = 4'h1;
						if (st.rnw) begin
							next_st.sdaOut = txByte[7];
							next_st.sdaOe = !txByte[7];
							next_st.shift = {txByte[6:0], 1'b0};
							next_st.bus = ST_READ;
						end else begin
							next_st.sdaOe = 1'b0;
							next_st.bitCnt = 4'h0;
							next_st.bus = ST_WRITE;
						end
					end
				end
				ST_READ: begin
					if (sclFall) begin
						if (st.bitCnt == 4'h8) begin
							next_st.sdaOe = 1'b0;
							next_st.byteIdx = st.byteIdx + 3'h1;
							next_st.bus = ST_RACK;
						end else begin
							next_st.sdaOut = st.shift[7];
							next_st.sdaOe = !st.shift[7];
							next_st.shift = {st.shift[6:0], 1'b0};
							next_st.bitCnt = st.bitCnt + 4'h1;
						end
					end
				end
				ST_RACK: begin
					if (sclRise) begin
						next_st.bus = st.sdaSync[1] ? ST_SKIP : ST_ACK;
					end
				end
				default: begin
					next_st.sdaOe = 1'b0;
				end
			endcase
		end

		if (timerDone) begin
			if (st.meas == MS_CONV) begin
				next_st.measDone = 1'b1;
			end
			next_st.meas = MS_IDLE;
			next_st.inReset = 1'b0;
		end
		next_st.sdaOut = next_st.sdaOe ? next_st.sdaOut : 1'b0;
		// status kept in flops so the pins never see decode glitches
		next_st.busy = (next_st.meas == MS_CONV);
		next_st.ready = (next_st.meas != MS_RESET);
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
			st.sclSync <= 2'h3;
			st.sdaSync <= 2'h3;
			st.rstSync <= 2'h3;
			st.sclPrev <= 1'b1;
			st.sdaPrev <= 1'b1;
			st.ready <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	assign sdaOut = st.sdaOut;
	assign sdaOe = st.sdaOe;
	assign measBusy = st.busy;
	assign measDone = st.measDone;
	assign sensorReady = st.ready;
	assign humLevel = st.humLevel;
	assign tempLevel = st.tempLevel;
endmodule : hts_target

/* verilog/hts_consts.svh */
// constants for the humidity/temperature serial target front end
// How it works
// - strap low answers address 0x40, strap high answers 0x41.
// - reset pin held active at least 1 us triggers full reset.
// - internal reset sequence runs about 2 ms before normal operation.
// - serial logic is static; any slow serial clock is tolerated.
// - read data changes just after clock falls, holds until next fall.
// - humidity conversion 8.34/4.21/2.14/1.11 ms for levels 3..0.
// - temperature conversion 11.98/6.03/3.06/1.57 ms for levels 3..0.
// - alternate address disabled after reset; only factory can enable it.
// - conversion command starts combined measurement, two level bits each.
// - soft reset command reinitializes defaults within 5 ms.
`ifndef HTS_CONSTS_SVH
`define HTS_CONSTS_SVH
`define HTS_CLK_MHZ 40
`define HTS_ADDR_BASE 6'h20
`define HTS_RST_PULSE_NS 1000
`define HTS_RST_PULSE_CYC ((`HTS_RST_PULSE_NS * `HTS_CLK_MHZ + 999) / 1000)
`define HTS_RST_SEQ_US 2000
`define HTS_RST_SEQ_CYC (`HTS_RST_SEQ_US * `HTS_CLK_MHZ)
`define HTS_SOFT_RST_US 5000
`define HTS_SOFT_RST_CYC (`HTS_SOFT_RST_US * `HTS_CLK_MHZ)
`define HTS_HUM3_US 8340
`define HTS_HUM2_US 4210
`define HTS_HUM1_US 2140
`define HTS_HUM0_US 1110
`define HTS_TMP3_US 11980
`define HTS_TMP2_US 6030
`define HTS_TMP1_US 3060
`define HTS_TMP0_US 1570
`define HTS_CMD_CONV_MASK 8'he1
`define HTS_CMD_CONV 8'h40
`define HTS_CMD_RESET_MASK 8'hfe
`define HTS_CMD_RESET 8'h1e
`define HTS_CMD_READ_TRH 8'h00
`define HTS_CMD_READ_RH 8'h10
`define HTS_HUM_LSB 3
`define HTS_TMP_LSB 1
`endif

/* verilog/hts_pkg.sv */
// types for the humidity/temperature serial target front end
package hts_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_WRITE, ST_READ, ST_RACK, ST_SKIP} hts_bus_e;
	typedef enum logic [1:0] {MS_IDLE, MS_CONV, MS_RESET} hts_meas_e;
endpackage : hts_pkg

/* verilog/hts_timer.sv */
// countdown timer loaded with a cycle count, pulses done at zero
module hts_timer #(
	parameter int W = 32
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// control
	input wire logic load,
	input wire logic [W-1:0] count,
	// status
	output logic busy,
	output logic done
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic busy;
		logic done;
	} hts_tmr_s;
	hts_tmr_s st, next_st;
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		if (load) begin
			next_st.cnt = count;
			next_st.busy = 1'b1;
		end else if (st.busy) begin
			if (st.cnt <= W'(1)) begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
			end else begin
				next_st.cnt = st.cnt - W'(1);
			end
		end
	end
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign busy = st.busy;
	assign done = st.done;
endmodule : hts_timer

/* testbench/hts_checker.sv */
// assertion checker for the serial target front end
`include "hts_consts.svh"
module hts_checker #(
	parameter int RST_SEQ_CYC = 80000,
	parameter int SOFT_RST_CYC = 200000,
	parameter int US_CYC = 40
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset_n,
	// watched ports
	input wire logic sclIn,
	input wire logic rstPin_n,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic measBusy,
	input wire logic measDone,
	input wire logic sensorReady,
	input wire logic [1:0] humLevel,
	input wire logic [1:0] tempLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	logic [6:0] lowCnt;
	int rdyLow;
	int busyCnt;
	// saturates so a long pin pulse never wraps
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			lowCnt <= 7'h00;
		end else if (rstPin_n) begin
			lowCnt <= 7'h00;
		end else if (lowCnt != 7'h7f) begin
			lowCnt <= lowCnt + 7'h01;
		end
	end
	// run lengths far beyond what a repetition count may unroll
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			rdyLow <= 0;
			busyCnt <= 0;
		end else begin
			rdyLow <= sensorReady ? 0 : rdyLow + 1;
			busyCnt <= measBusy ? busyCnt + 1 : 0;
		end
	end
	property p_rst_len;
		$rose(sensorReady) |-> $past(rdyLow) >= RST_SEQ_CYC;
	endproperty
	a_rst_len: assert property (p_rst_len) else $error("reset sequence too short");
	property p_rst_max;
		rdyLow <= RST_SEQ_CYC + SOFT_RST_CYC + 4;
	endproperty
	a_rst_max: assert property (p_rst_max) else $error("reset sequence too long");
	property p_conv_len;
		measDone |-> busyCnt >= US_CYC * `HTS_TMP0_US &&
			busyCnt <= US_CYC * `HTS_TMP3_US + 4;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion span wrong");
	property p_pin_rst;
		lowCnt == 7'h30 |-> !sensorReady && !sdaOe && !measBusy;
	endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("pin reset not taken");
	property p_rst_hold;
		$fell(sensorReady) |-> !sensorReady [*8];
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("reset too short");
	property p_oe_low;
		$changed(sdaOe) |-> !sclIn;
	endproperty
	a_oe_low: assert property (p_oe_low) else $error("data moved in clock high");
	property p_od;
		!sdaOut;
	endproperty
	a_od: assert property (p_od) else $error("data driven high");
	property p_done_pulse;
		measDone |=> !measDone;
	endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done too long");
	property p_done_busy;
		measDone |-> $past(measBusy) && !measBusy;
	endproperty
	a_done_busy: assert property (p_done_busy) else $error("done without busy");
	property p_busy_min;
		$rose(measBusy) |-> measBusy [*8];
	endproperty
	a_busy_min: assert property (p_busy_min) else $error("conversion too short");
	property p_lvl;
		$changed({humLevel, tempLevel}) |-> ##[0:2] (measBusy || !sensorReady);
	endproperty
	a_lvl: assert property (p_lvl) else $error("levels moved alone");
	c_done: cover property (measDone);
	c_rst: cover property ($fell(sensorReady));
	c_ack: cover property ($rose(sdaOe));
endmodule : hts_checker
bind hts_target hts_checker #(.RST_SEQ_CYC(RST_SEQ_CYC), .SOFT_RST_CYC(SOFT_RST_CYC),
	.US_CYC(US_CYC)) chk (.core_clk(core_clk), .reset_n(reset_n), .sclIn(sclIn),
	.rstPin_n(rstPin_n), .sdaOut(sdaOut), .sdaOe(sdaOe), .measBusy(measBusy),
	.measDone(measDone), .sensorReady(sensorReady), .humLevel(humLevel),
	.tempLevel(tempLevel));

/* testbench/hts_ctrl_model.sv */
// serial bus controller model, clock and open-drain data
module hts_ctrl_model (
	// bench clock
	input wire logic core_clk,
	// bus
	input wire logic sda,
	output logic scl,
	output logic sdaLow
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	// clock stays high between frames
	task automatic bitx(input logic b, output logic r);
		cyc(2);
		sdaLow = !b;
		cyc(6);
		scl = 1'b1;
		cyc(6);
		r = sda;
		scl = 1'b0;
	endtask : bitx
	task automatic start();
		cyc(6);
		sdaLow = 1'b1;
		cyc(6);
		scl = 1'b0;
	endtask : start
	task automatic stop();
		cyc(2);
		sdaLow = 1'b1;
		cyc(6);
		scl = 1'b1;
		cyc(6);
		sdaLow = 1'b0;
		cyc(6);
	endtask : stop
	task automatic wb(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(d[i], r);
		bitx(1'b1, r);
		ack = !r;
	endtask : wb
	task automatic rb(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bitx(1'b1, d[i]);
		bitx(last, r);
	endtask : rb
endmodule : hts_ctrl_model

/* testbench/tb_humidity_temp_i2c_target_timing.sv */
// self-checking bench for the serial target front end
module tb_humidity_temp_i2c_target_timing;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, reset_n, scl, sdaLow, sdaOut, sdaOe, strap, rstPin_n, altEn;
	logic measBusy, measDone, sensorReady;
	logic [1:0] humLevel, tempLevel;
	logic [6:0] altAddr;
	logic [15:0] tData, hData;
	int mismatches = 0;
	int nChecks = 0;
	wire sda = !(sdaLow || sdaOe);
	hts_target #(.RST_SEQ_CYC(20), .SOFT_RST_CYC(300), .US_CYC(1)) dut (
		.core_clk(core_clk), .reset_n(reset_n), .sclIn(scl), .sdaIn(sda),
		.sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelectStrap(strap), .rstPin_n(rstPin_n),
		.altAddrEnable(altEn), .altAddr(altAddr), .tempData(tData), .humData(hData),
		.measBusy(measBusy), .measDone(measDone), .sensorReady(sensorReady),
		.humLevel(humLevel), .tempLevel(tempLevel));
	hts_ctrl_model mdl (.core_clk(core_clk), .sda(sda), .scl(scl), .sdaLow(sdaLow));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = !core_clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		nChecks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic chkN(input int n, input int lo, input int hi);
		nChecks++;
		if (n < lo || n > hi) begin
			mismatches++;
			$display("unexpected at %0t: count %0d", $time, n);
		end
	endtask : chkN
	function automatic int convUs(input logic [1:0] h, input logic [1:0] t);
		int hu[4] = '{1110, 2140, 4210, 8340};
		int tu[4] = '{1570, 3060, 6030, 11980};
		return (hu[h] > tu[t]) ? hu[h] : tu[t];
	endfunction : convUs
	task automatic cmd(input logic [6:0] a, input logic [7:0] c, output logic ack);
		logic k;
		mdl.start();
		mdl.wb({a, 1'b0}, ack);
		if (ack)
			mdl.wb(c, k);
		mdl.stop();
	endtask : cmd
	// waits for ready to drop, then counts how long it stays low
	task automatic lowSpan(output int n);
		n = 0;
		while (sensorReady === 1'b1 && n < 100) begin
			mdl.cyc(1);
			n++;
		end
		n = 0;
		while (sensorReady !== 1'b1 && n < 1000) begin
			mdl.cyc(1);
			n++;
		end
	endtask : lowSpan
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", nChecks, mismatches);
		if (mismatches == 0 && nChecks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up
	initial begin
		#2000000;
		mismatches++;
		wrap_up();
	end
	initial begin
		int n;
		logic ack;
		logic [1:0] h, t;
		logic [7:0] d;
		logic [6:0] a;
		logic [39:0] e;
		n = $urandom(67);
		{reset_n, strap, altEn, altAddr, tData, hData} = '0;
		rstPin_n = 1'b1;
		repeat (2) @(posedge core_clk);
		#1 reset_n = 1'b1;
		mdl.cyc(4);
		altAddr = 7'($urandom) & 7'h3f;
		for (int k = 0; k < 3; k++) begin
			h = (k == 0) ? 2'h3 : (k == 1) ? 2'h0 : 2'(1 + $urandom % 3);
			t = (k == 0) ? 2'h3 : (k == 1) ? 2'h0 : 2'($urandom);
			strap = (k == 2) ? 1'($urandom) : k[0];
			{tData, hData} = {16'($urandom), 16'($urandom)};
			a = {6'h20, strap};
			mdl.cyc(4);
			cmd(a ^ 7'h01, 8'h40, ack);
			chk(16'(ack), 16'h0);
			cmd(a, {3'h2, h, t, 1'b0}, ack);
			chk(16'(ack), 16'h1);
			chk(16'({humLevel, tempLevel}), 16'({h, t}));
			n = 0;
			while (measBusy === 1'b1 && n < 20000) begin
				mdl.cyc(1);
				n++;
			end
			chkN(n, convUs(h, t) - 40, convUs(h, t));
			chk(16'(measDone), 16'h1);
			cmd(a, (k == 1) ? 8'h10 : 8'h00, ack);
			mdl.start();
			mdl.wb({a, 1'b1}, ack);
			e = (k == 1) ? {hData, 24'h000000} : {tData, 8'h00, hData};
			for (int i = 0; i < 5; i++) begin
				mdl.rb(i == 4, d);
				chk(16'(d), 16'(e[39 - 8 * i -: 8]));
			end
			mdl.stop();
		end
		cmd(altAddr, 8'h00, ack);
		chk(16'(ack), 16'h0);
		altEn = 1'b1;
		mdl.cyc(4);
		cmd(altAddr, 8'h00, ack);
		chk(16'(ack), 16'h1);
		cmd(a, 8'h1e, ack);
		lowSpan(n);
		chkN(n, 250, 300);
		chk(16'({humLevel, tempLevel}), 16'h0);
		cmd(a, 8'h4c, ack);
		rstPin_n = 1'b0;
		mdl.cyc(48 + int'($urandom % 8));
		rstPin_n = 1'b1;
		chk(16'({sensorReady, measBusy, humLevel, tempLevel}), 16'h0);
		lowSpan(n);
		chkN(n, 5, 20);
		wrap_up();
	end
endmodule : tb_humidity_temp_i2c_target_timing
